/* File: src/tmch_pkg.sv */
// Constants and types shared by the terminal modem control handshake.
// Assumes a single 125 MHz core clock and a plain register port.
package tmch_pkg;

  // ********************
  // Bus geometry
  // ********************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // ********************
  // Register offsets
  // ********************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQS = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQM = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_BTXD = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_BAUD = 5'h14;

  // ********************
  // Control fields
  // ********************
  localparam int C_DTR    = 0;
  localparam int C_CONN   = 1;
  localparam int C_AUTO   = 2;
  localparam int C_VIACON = 3;
  localparam int C_RXP    = 4;
  localparam int C_RLB    = 5;
  localparam int C_LLB    = 6;
  localparam int C_TESTC  = 7;
  localparam int C_BLOCK  = 8;
  localparam int C_HOLD   = 9;
  localparam int C_HANGUP = 10;
  localparam int CTRL_W   = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  // ********************
  // Interrupt fields
  // ********************
  localparam int I_RING  = 0;
  localparam int I_TON   = 1;
  localparam int I_TOFF  = 2;
  localparam int I_CD    = 3;
  localparam int I_TXD   = 4;
  localparam int I_INC   = 5;
  localparam int I_LATE  = 6;
  localparam int IRQ_W   = 7;
  localparam logic [IRQ_W-1:0] IRQ_RST = 7'h00;

  localparam logic [15:0] BAUD_RST = 16'h043c;

  // ********************
  // Timing
  // ********************
  localparam int CLK_MHZ     = 125;
  localparam int GLITCH_NS   = 1000;
  localparam int GLITCH_CYC  = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int ANSWER_MS   = 500;
  localparam int ANSWER_CYC  = ANSWER_MS * CLK_MHZ * 1000;
  localparam int RING_GAP_MS = 6000;
  localparam int RING_GAP_CYC = RING_GAP_MS * CLK_MHZ * 1000;

  // ********************
  // State types
  // ********************
  typedef enum logic [3:0] {
    BT_IDLE = 4'b0001,
    BT_CD   = 4'b0010,
    BT_RDY  = 4'b0100,
    BT_SEND = 4'b1000
  } tmch_bt_type;

  typedef enum logic [2:0] {
    TS_RUN  = 3'b001,
    TS_STBY = 3'b010,
    TS_TEST = 3'b100
  } tmch_ts_type;

endpackage : tmch_pkg

/* File: src/tmch_sync_filter.sv */
// Three-stage synchroniser with a stability filter for one modem input.
// Assumes the pin is asynchronous to core_clk_i.
module tmch_sync_filter
  import tmch_pkg::*;
#(
  parameter int STABLE_CYC = GLITCH_CYC
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // Pin and filtered result
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  localparam int CW = $clog2(STABLE_CYC + 1);

  logic          s1_reg, s2_reg, s3_reg;
  logic          level_reg, rise_reg, fall_reg;
  logic [CW-1:0] cnt_reg;

  wire agree  = s2_reg == s3_reg;
  wire differ = agree && (s3_reg != level_reg);
  wire done   = cnt_reg == CW'(STABLE_CYC - 1);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
      cnt_reg   <= '0;
    end else begin
      s1_reg   <= pin_i;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      if (!differ) begin
        cnt_reg <= '0;
      end else if (done) begin
        level_reg <= s3_reg;
        rise_reg  <= s3_reg;
        fall_reg  <= !s3_reg;
        cnt_reg   <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign level_o = level_reg;
  assign rise_o  = rise_reg;
  assign fall_o  = fall_reg;

  property p_filt_rise;
    @(posedge core_clk_i) disable iff (reset_i)
    rise_o |-> $past(s2_reg) && $past(s3_reg) && level_o;
  endproperty
  a_filt_rise: assert property (p_filt_rise) else $error("rise without agreement");

endmodule : tmch_sync_filter

/* File: src/tmch_bchan_tx.sv */
// Start-stop serialiser for the backward channel transmit line.
// Assumes bit_en_i is a one-cycle pulse at the bit rate.
module tmch_bchan_tx
  import tmch_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       bit_en_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [7:0] data_i,
  // Status and line
  output logic            busy_o,
  output logic            done_o,
  output logic            txd_o
);

  logic [9:0] sh_reg;
  logic [3:0] cnt_reg;
  logic       busy_reg, done_reg, txd_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sh_reg   <= 10'h3ff;
      cnt_reg  <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      txd_reg  <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      if (abort_i) begin
        busy_reg <= 1'b0;
        txd_reg  <= 1'b1;
      end else if (start_i && !busy_reg) begin
        sh_reg   <= {1'b1, data_i, 1'b0};
        cnt_reg  <= 4'ha;
        busy_reg <= 1'b1;
      end else if (busy_reg && bit_en_i) begin
        if (cnt_reg != 4'h0) begin
          txd_reg <= sh_reg[0];
          sh_reg  <= {1'b1, sh_reg[9:1]};
          cnt_reg <= cnt_reg - 4'h1;
        end else begin
          // Stop bit has ended here
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          txd_reg  <= 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign txd_o  = txd_reg;

endmodule : tmch_bchan_tx

/* File: src/tmch_top.sv */
// Terminal side modem control handshake: backward channel, ring, test.
// Assumes modem pins are asynchronous; inc_notice_i is on core_clk_i.
//
// Overview of operation
// - Backward data idle until channel ready on
// - Backward request output always uses ready input
// - Monitor backward carrier detect for turnaround
// - Block protocol mode makes carrier detect optional
// - Auto answer via connect monitors ring
// - Answer-only terminal ready monitors ring
// - Auto answer watches ring or incoming notice
// - Terminal ready on within 500 ms
// - Optional receive permit output to modem
// - Loopback requests require test indicator monitoring
// - Test indicator on stops data communication
// - Standby stays idle until test off
// - Request not raised while carrier detect on
// - Request held past last bit end
module tmch_top
  import tmch_pkg::*;
#(
  parameter int ANS_CYC = ANSWER_CYC,
  parameter int GAP_CYC = RING_GAP_CYC,
  parameter int FLT_CYC = GLITCH_CYC
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Modem inputs
  input  wire logic              bchan_ready_i,
  input  wire logic              bchan_cd_i,
  input  wire logic              ring_i,
  input  wire logic              test_ind_i,
  input  wire logic              inc_notice_i,
  // Modem outputs
  output logic                   bchan_txd_o,
  output logic                   bchan_req_o,
  output logic                   term_ready_o,
  output logic                   connect_o,
  output logic                   rx_permit_o,
  output logic                   remote_lb_o,
  output logic                   local_lb_o,
  // Local status
  output logic                   data_halt_o,
  output logic                   test_state_o,
  output logic                   irq_o
);

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // ********************
  // Input conditioning
  // ********************
  logic rdy_lvl, cd_lvl, cd_rise, ring_lvl, ring_rise;
  logic test_lvl, test_rise, test_fall;

  tmch_sync_filter #(.STABLE_CYC(FLT_CYC)) u_rdy (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .pin_i      (bchan_ready_i),
    .level_o    (rdy_lvl),
    .rise_o     (),
    .fall_o     ()
  );

  tmch_sync_filter #(.STABLE_CYC(FLT_CYC)) u_cd (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .pin_i      (bchan_cd_i),
    .level_o    (cd_lvl),
    .rise_o     (cd_rise),
    .fall_o     ()
  );

  tmch_sync_filter #(.STABLE_CYC(FLT_CYC)) u_ring (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .pin_i      (ring_i),
    .level_o    (ring_lvl),
    .rise_o     (ring_rise),
    .fall_o     ()
  );

  tmch_sync_filter #(.STABLE_CYC(FLT_CYC)) u_test (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .pin_i      (test_ind_i),
    .level_o    (test_lvl),
    .rise_o     (test_rise),
    .fall_o     (test_fall)
  );

  // ********************
  // Register decode
  // ********************
  logic [CTRL_W-1:0] ctrl_reg;
  logic [IRQ_W-1:0]  irqs_reg, irqm_reg;
  logic [7:0]        btxd_reg;
  logic [15:0]       baud_reg;

  wire wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;
  wire wr_irqs = reg_wr_i && reg_addr_i == OFS_IRQS;
  wire wr_irqm = reg_wr_i && reg_addr_i == OFS_IRQM;
  wire wr_btxd = reg_wr_i && reg_addr_i == OFS_BTXD;
  wire wr_baud = reg_wr_i && reg_addr_i == OFS_BAUD;
  wire hangup  = wr_ctrl && reg_wdata_i[C_HANGUP];

  // ********************
  // Test indicator
  // ********************
  tmch_ts_type ts_reg, ts_next;

  always_comb begin
    ts_next = ts_reg;
    unique case (ts_reg)
      TS_RUN: begin
        if (test_lvl) begin
          ts_next = ctrl_reg[C_TESTC] ? TS_TEST : TS_STBY;
        end
      end
      TS_STBY: begin
        if (!test_lvl) begin
          ts_next = TS_RUN;
        end
      end
      TS_TEST: begin
        if (!test_lvl) begin
          ts_next = TS_RUN;
        end
      end
    endcase
  end

  wire halted   = ts_reg != TS_RUN;
  wire halt_now = ts_next != TS_RUN;

  // ********************
  // Bit rate divider
  // ********************
  logic [15:0] div_reg;
  // Catches up at once when the divisor shrinks
  wire         bit_en = div_reg >= baud_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i || bit_en) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // ********************
  // Backward channel send
  // ********************
  tmch_bt_type bt_reg, bt_next;
  logic        req_reg, req_next;
  logic        pend_reg;
  logic        tx_busy, tx_done;

  wire cd_clear = !cd_lvl || ctrl_reg[C_BLOCK];
  wire tx_start = bt_reg == BT_RDY && rdy_lvl;
  wire in_send  = bt_reg == BT_SEND;

  always_comb begin
    bt_next  = bt_reg;
    req_next = req_reg;
    unique case (bt_reg)
      BT_IDLE: begin
        if (!ctrl_reg[C_HOLD]) begin
          req_next = 1'b0;
        end
        if (pend_reg) begin
          bt_next = BT_CD;
        end
      end
      BT_CD: begin
        if (req_reg || cd_clear) begin
          req_next = 1'b1;
          bt_next  = BT_RDY;
        end
      end
      BT_RDY: begin
        if (rdy_lvl) begin
          bt_next = BT_SEND;
        end
      end
      BT_SEND: begin
        if (tx_done) begin
          req_next = ctrl_reg[C_HOLD];
          bt_next  = BT_IDLE;
        end
      end
    endcase
    if (halted || halt_now) begin
      bt_next  = BT_IDLE;
      req_next = 1'b0;
    end
  end

  tmch_bchan_tx u_tx (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .bit_en_i   (bit_en),
    .start_i    (tx_start),
    .abort_i    (halted),
    .data_i     (btxd_reg),
    .busy_o     (tx_busy),
    .done_o     (tx_done),
    .txd_o      (bchan_txd_o)
  );

  // ********************
  // Ring and answer
  // ********************
  logic        ring_act_reg, ans_reg, late_reg;
  logic [31:0] gap_reg, ans_cnt_reg;

  wire gap_end  = gap_reg == 32'(GAP_CYC - 1);
  wire ans_due  = ans_cnt_reg == 32'(ANS_CYC - 1);
  wire ans_trig = ctrl_reg[C_AUTO] && !halted && (ring_act_reg || inc_notice_i);
  wire ans_wait = ctrl_reg[C_AUTO] && ring_act_reg && !ans_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ring_act_reg <= 1'b0;
      gap_reg      <= 32'h0;
    end else if (ring_lvl) begin
      ring_act_reg <= 1'b1;
      gap_reg      <= 32'h0;
    end else if (ring_act_reg) begin
      ring_act_reg <= !gap_end;
      gap_reg      <= gap_end ? 32'h0 : gap_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ans_reg     <= 1'b0;
      ans_cnt_reg <= 32'h0;
      late_reg    <= 1'b0;
    end else begin
      late_reg <= 1'b0;
      if (hangup || halted) begin
        ans_reg <= 1'b0;
      end else if (ans_trig) begin
        ans_reg <= 1'b1;
      end
      if (!ans_wait) begin
        ans_cnt_reg <= 32'h0;
      end else if (ans_due) begin
        late_reg    <= 1'b1;
        ans_cnt_reg <= 32'h0;
      end else begin
        ans_cnt_reg <= ans_cnt_reg + 32'h1;
      end
    end
  end

  // ********************
  // Events and interrupt
  // ********************
  logic [IRQ_W-1:0] ev;

  assign ev[I_RING] = ring_rise;
  assign ev[I_TON]  = test_rise;
  assign ev[I_TOFF] = test_fall;
  assign ev[I_CD]   = cd_rise;
  assign ev[I_TXD]  = tx_done;
  assign ev[I_INC]  = inc_notice_i;
  assign ev[I_LATE] = late_reg;

  wire [IRQ_W-1:0] irq_clr = wr_irqs ? reg_wdata_i[IRQ_W-1:0] : '0;

  // ********************
  // Register storage
  // ********************
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RST;
      irqs_reg <= IRQ_RST;
      irqm_reg <= IRQ_RST;
      btxd_reg <= 8'h00;
      baud_reg <= BAUD_RST;
      pend_reg <= 1'b0;
      ts_reg   <= TS_RUN;
      bt_reg   <= BT_IDLE;
      req_reg  <= 1'b0;
    end else begin
      ts_reg   <= ts_next;
      bt_reg   <= bt_next;
      req_reg  <= req_next;
      irqs_reg <= (irqs_reg & ~irq_clr) | ev;
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata_i[CTRL_W-1:0];
      end
      if (wr_irqm) begin
        irqm_reg <= reg_wdata_i[IRQ_W-1:0];
      end
      if (wr_baud) begin
        baud_reg <= reg_wdata_i;
      end
      if (halted || tx_start) begin
        pend_reg <= 1'b0;
      end else if (wr_btxd && !pend_reg && bt_reg == BT_IDLE) begin
        btxd_reg <= reg_wdata_i[7:0];
        pend_reg <= 1'b1;
      end
    end
  end

  // ********************
  // Read port
  // ********************
  wire [DATA_W-1:0] stat = {7'h00, test_state_o, halted, tx_busy,
                            ans_reg, ring_act_reg, test_lvl, ring_lvl,
                            cd_lvl, rdy_lvl};
  logic [DATA_W-1:0] rsel;

  always_comb begin
    unique case (reg_addr_i)
      OFS_CTRL: rsel = DATA_W'(ctrl_reg);
      OFS_STAT: rsel = stat;
      OFS_IRQS: rsel = DATA_W'(irqs_reg);
      OFS_IRQM: rsel = DATA_W'(irqm_reg);
      OFS_BTXD: rsel = {8'h00, btxd_reg};
      OFS_BAUD: rsel = baud_reg;
      default:  rsel = '0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rsel : '0;
    end
  end

  // ********************
  // Pin outputs
  // ********************
  assign bchan_req_o  = req_reg;
  assign term_ready_o = ctrl_reg[C_DTR] | (ans_reg & !ctrl_reg[C_VIACON]);
  assign connect_o    = ctrl_reg[C_CONN] | (ans_reg & ctrl_reg[C_VIACON]);
  assign rx_permit_o  = ctrl_reg[C_RXP] & !halted;
  assign remote_lb_o  = ctrl_reg[C_RLB];
  assign local_lb_o   = ctrl_reg[C_LLB];
  assign data_halt_o  = halted;
  assign test_state_o = ts_reg == TS_TEST;
  assign irq_o        = |(irqs_reg & irqm_reg);

  // ********************
  // Checks
  // ********************
  property p_txd_gate;
    $fell(bchan_txd_o) |-> $past(in_send) && $past(rdy_lvl, 2);
  endproperty
  a_txd_gate: assert property (p_txd_gate) else $error("data before ready");

  property p_start_req;
    tx_start |-> req_reg && rdy_lvl;
  endproperty
  a_start_req: assert property (p_start_req) else $error("start without req");

  property p_req_cd;
    $rose(req_reg) |-> $past(cd_clear);
  endproperty
  a_req_cd: assert property (p_req_cd) else $error("req raised under carrier");

  property p_req_hold;
    $fell(req_reg) |-> !$past(tx_busy) || $past(halt_now);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req dropped mid bit");

  property p_cd_irq;
    cd_rise && !wr_irqs |=> irqs_reg[I_CD];
  endproperty
  a_cd_irq: assert property (p_cd_irq) else $error("carrier event lost");

  property p_answer;
    ring_rise && ctrl_reg[C_AUTO] && !halted && !hangup ##1 !halted && !hangup
      |-> ##[1:2] ans_reg;
  endproperty
  a_answer: assert property (p_answer) else $error("answer too late");

  property p_inc_ans;
    inc_notice_i && ctrl_reg[C_AUTO] && !halted && !hangup |=> ans_reg;
  endproperty
  a_inc_ans: assert property (p_inc_ans) else $error("notice not answered");

  property p_ring_gap;
    ring_act_reg && !ring_lvl && !gap_end |=> ring_act_reg;
  endproperty
  a_ring_gap: assert property (p_ring_gap) else $error("ring gap dropped");

  property p_test_halt;
    test_lvl && ts_reg == TS_RUN |=> data_halt_o && !bchan_req_o ##1 !tx_busy;
  endproperty
  a_test_halt: assert property (p_test_halt) else $error("no halt on test");

  property p_standby;
    ts_reg == TS_STBY && test_lvl |=> ts_reg == TS_STBY && !rx_permit_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left early");

  property p_test_irq;
    test_rise && !wr_irqs |=> irqs_reg[I_TON];
  endproperty
  a_test_irq: assert property (p_test_irq) else $error("test event lost");

  c_tx_done: cover property (tx_done);
  c_standby: cover property (ts_reg == TS_STBY ##1 ts_reg == TS_RUN);
  c_test:    cover property (test_state_o);
  c_answer:  cover property ($rose(ans_reg));

endmodule : tmch_top

/* File: verif/tmch_modem_model.sv */
// Modem model for backward channel, ring and test indicator lines.
// Assumes the bench sets the carrier, ring and test commands.
module tmch_modem_model (
  // Clock
  input  wire logic       core_clk_i,
  // Bench commands
  input  wire logic       cd_cmd_i,
  input  wire logic       ring_cmd_i,
  input  wire logic       test_cmd_i,
  input  wire logic [7:0] rdy_dly_i,
  // Terminal side
  input  wire logic       bchan_req_i,
  output logic            bchan_ready_o,
  output logic            bchan_cd_o,
  output logic            ring_o,
  output logic            test_ind_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt   = 8'h00;
  logic [6:0] ph    = 7'h00;
  logic       rdy_q = 1'b0;

  assign bchan_ready_o = rdy_q;

  // ********************
  // Ready answers the request after a delay
  // ********************
  always @(posedge core_clk_i) begin
    if (!bchan_req_i) begin
      cnt <= 8'h00;
      rdy_q <= 1'b0;
    end else if (cnt >= rdy_dly_i) begin
      rdy_q <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
    // Cadence restarts with each ring command
    ph <= (!ring_cmd_i || ph == 7'h4f) ? 7'h00 : ph + 7'h01;
  end

  // Ring pulses with a cadence
  assign ring_o = ring_cmd_i && (ph < 7'h28);
  assign bchan_cd_o = cd_cmd_i;
  assign test_ind_o = test_cmd_i;
endmodule : tmch_modem_model

/* File: verif/test_tmch_top.sv */
// Bench for the terminal modem control handshake top.
// Assumes the modem model on the far side and shortened counts.
module test_tmch_top
  import tmch_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        w;
    logic [4:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } tmch_row_type;

  logic              core_clk_i, reset_i, reg_wr_i, reg_rd_i, inc_notice_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, rd_v;
  logic              cd_cmd, ring_cmd, test_cmd;
  logic [7:0]        rdy_dly;
  logic              rdy, cd, ring, tind, txd, req, term_ready_o, connect_o;
  logic              rx_permit_o, remote_lb_o, local_lb_o, data_halt_o, test_state_o, irq_o;
  logic [9:0]        bits;
  int                n_fail, n_tests, i, lows;
  tmch_row_type      rows [8] = '{
    '{1'b0, OFS_CTRL, 16'h0000, 16'h0000}, '{1'b0, OFS_BAUD, 16'h0000, 16'h043c},
    '{1'b0, OFS_IRQM, 16'h0000, 16'h0000}, '{1'b0, OFS_STAT, 16'h0000, 16'h0000},
    '{1'b1, 5'h18, 16'hffff, 16'h0000},    '{1'b1, OFS_STAT, 16'hffff, 16'h0000},
    '{1'b1, OFS_CTRL, 16'h0470, 16'h0070}, '{1'b1, OFS_BAUD, 16'h0003, 16'h0003}};

  tmch_top #(.ANS_CYC(200), .GAP_CYC(300), .FLT_CYC(4)) dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .bchan_ready_i(rdy), .bchan_cd_i(cd), .ring_i(ring),
    .test_ind_i(tind), .inc_notice_i(inc_notice_i), .bchan_txd_o(txd), .bchan_req_o(req),
    .term_ready_o(term_ready_o), .connect_o(connect_o), .rx_permit_o(rx_permit_o),
    .remote_lb_o(remote_lb_o), .local_lb_o(local_lb_o), .data_halt_o(data_halt_o),
    .test_state_o(test_state_o), .irq_o(irq_o));

  tmch_modem_model modem (
    .core_clk_i(core_clk_i), .cd_cmd_i(cd_cmd), .ring_cmd_i(ring_cmd),
    .test_cmd_i(test_cmd), .rdy_dly_i(rdy_dly), .bchan_req_i(req),
    .bchan_ready_o(rdy), .bchan_cd_o(cd), .ring_o(ring), .test_ind_o(tind));

  // ********************
  // Helpers
  // ********************
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wt

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask : rd

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic conclude;
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  initial begin
    #100000;
    n_fail++;
    conclude();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    {reset_i, reg_wr_i, reg_rd_i, inc_notice_i} = 4'b1000;
    {cd_cmd, ring_cmd, test_cmd} = 3'b000;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    rdy_dly = 8'd30;
    n_fail = 0;
    n_tests = 0;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    wt(1);
    chk({txd, req, term_ready_o, connect_o, data_halt_o, irq_o}, 6'h20);
    foreach (rows[k]) begin
      if (rows[k].w)
        wr(rows[k].a, rows[k].d);
      rd(rows[k].a);
      chk(rd_v, rows[k].e);
    end
    chk({rx_permit_o, remote_lb_o, local_lb_o}, 3'b111);
    // Short glitch on test indicator is ignored
    @(posedge core_clk_i) test_cmd <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    test_cmd <= 1'b0;
    wt(20);
    chk(data_halt_o, 1'b0);
    @(posedge core_clk_i) test_cmd <= 1'b1;
    wt(12);
    chk({data_halt_o, test_state_o, rx_permit_o}, 3'b100);
    wt(100);
    chk(data_halt_o, 1'b1);
    @(posedge core_clk_i) test_cmd <= 1'b0;
    wt(12);
    chk({data_halt_o, rx_permit_o}, 2'b01);
    rd(OFS_IRQS);
    chk(rd_v[2:1], 2'b11);
    wr(OFS_CTRL, 16'h00f0);
    @(posedge core_clk_i) test_cmd <= 1'b1;
    wt(12);
    chk({data_halt_o, test_state_o}, 2'b11);
    @(posedge core_clk_i) test_cmd <= 1'b0;
    wt(12);
    // Backward send, carrier on first, second byte refused
    wr(OFS_CTRL, 16'h0000);
    @(posedge core_clk_i) cd_cmd <= 1'b1;
    wt(12);
    wr(OFS_BTXD, 16'h00a5);
    wr(OFS_BTXD, 16'h003c);
    wt(30);
    chk({req, txd}, 2'b01);
    @(posedge core_clk_i) cd_cmd <= 1'b0;
    for (i = 0; i < 100 && txd !== 1'b0; i++) begin
      if (rdy !== 1'b1)
        chk(txd, 1'b1);
      wt(1);
    end
    chk(rdy, 1'b1);
    wt(2);
    for (i = 0; i < 10; i++) begin
      bits[i] = txd;
      chk(req, 1'b1);
      wt(4);
    end
    chk(bits, 10'h34a);
    lows = 0;
    for (i = 0; i < 80; i++) begin
      lows += (txd !== 1'b1);
      wt(1);
    end
    chk({lows[7:0], req}, 9'h000);
    rd(OFS_IRQS);
    chk({rd_v[4], irq_o}, 2'b10);
    wr(OFS_IRQM, 16'h0010);
    wt(2);
    chk(irq_o, 1'b1);
    wr(OFS_IRQS, 16'h007f);
    wt(2);
    chk(irq_o, 1'b0);
    // Auto answer on pulsed ring
    wr(OFS_CTRL, 16'h0004);
    wr(OFS_IRQM, 16'h0001);
    @(posedge core_clk_i) ring_cmd <= 1'b1;
    for (i = 0; i < 20 && term_ready_o !== 1'b1; i++)
      wt(1);
    chk({term_ready_o, irq_o}, 2'b11);
    wt(300);
    chk(term_ready_o, 1'b1);
    rd(OFS_STAT);
    chk(rd_v[5:4], 2'b11);
    @(posedge core_clk_i) ring_cmd <= 1'b0;
    wr(OFS_CTRL, 16'h0400);
    wt(2);
    chk(term_ready_o, 1'b0);
    // Incoming call notice answers on connect
    wt(320);
    wr(OFS_CTRL, 16'h000c);
    wt(2);
    chk(connect_o, 1'b0);
    @(posedge core_clk_i) inc_notice_i <= 1'b1;
    @(posedge core_clk_i) inc_notice_i <= 1'b0;
    wt(2);
    chk({connect_o, term_ready_o}, 2'b10);
    // Reset in mid-run returns every output to idle
    @(posedge core_clk_i) reset_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    wt(1);
    chk({txd, req, term_ready_o, connect_o, data_halt_o, irq_o}, 6'h20);
    rd(OFS_CTRL);
    chk(rd_v, 16'h0000);
    conclude();
  end
endmodule : test_tmch_top
